// [inc/nim_map.vh]
// register map and field positions for the irq mask and drop counters, reset value for the irq mask
`ifndef NIM_MAP_VH
`define NIM_MAP_VH

// ============================================================
// register byte addresses (word aligned)
`define NIM_ADDR_W          4
`define NIM_OFF_IRQ_MASK    4'h0
`define NIM_OFF_DROP_CNT    4'h4
`define NIM_OFF_STATUS_VIEW 4'h8

// ============================================================
// mask register fields
`define NIM_BIT_NORMAL_SUM    16
`define NIM_BIT_ABNORMAL_SUM  15
`define NIM_BIT_EARLY_RX      14
`define NIM_BIT_BUS_ERR       13
`define NIM_BIT_LINK_CHG      12
`define NIM_BIT_TIMER         11
`define NIM_BIT_EARLY_TX      10
`define NIM_BIT_RX_WDOG       9
`define NIM_BIT_RX_STOP       8
`define NIM_BIT_RX_NOBUF      7
`define NIM_BIT_RX_DONE       6
`define NIM_BIT_TX_UNDER      5
`define NIM_BIT_RESERVED      4
`define NIM_BIT_TX_JABBER     3
`define NIM_BIT_TX_NOBUF      2
`define NIM_BIT_TX_STOP       1
`define NIM_BIT_TX_DONE       0
`define NIM_MASK_WIDTH        17
`define NIM_MASK_RESET        17'h0_0000
`define NIM_MASK_WRITABLE     17'h1_FFEF

// ============================================================
// drop counter fields
`define NIM_PURGED_WRAP_BIT   31
`define NIM_PURGED_MSB        30
`define NIM_PURGED_LSB        17
`define NIM_PURGED_WIDTH      14
`define NIM_MISSED_WRAP_BIT   16
`define NIM_MISSED_MSB        15
`define NIM_MISSED_LSB        0
`define NIM_MISSED_WIDTH      16

// ============================================================
// status field for bus error kind
`define NIM_ERRKIND_MSB       24
`define NIM_ERRKIND_LSB       23

`endif

// [rtl/nim_drop_counter.v]
// saturation-free event counter with sticky wrap flag
`include "nim_map.vh"

module nim_drop_counter #(
  parameter WIDTH = 16
) (
  sysClk,
  rstB,
  countPulse,
  countValue,
  wrapFlag
);
  input              sysClk;
  input              rstB;
  input              countPulse;
  output [WIDTH-1:0] countValue;
  output             wrapFlag;

  reg  [WIDTH-1:0] count_reg;
  reg              wrap_reg;
  wire [WIDTH-1:0] allOnes;

  assign allOnes    = {WIDTH{1'b1}};
  assign countValue = count_reg;
  assign wrapFlag   = wrap_reg;

  // ============================================================
  // count events, remember any wrap past the top
  always @(posedge sysClk)
  begin
    if (!rstB)
    begin
      count_reg <= {WIDTH{1'b0}};
      wrap_reg  <= 1'b0;
    end
    else if (countPulse)
    begin
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      if (count_reg == allOnes)
        wrap_reg <= 1'b1;   // sticky until reset
    end
  end
endmodule // nim_drop_counter

// [rtl/nim_cause_gate.v]
// per-cause enable gating of status flags into group requests
`include "nim_map.vh"

module nim_cause_gate (
  statusIn,
  maskIn,
  causeActive,
  irqOut
);
  input  [16:0] statusIn;
  input  [16:0] maskIn;
  output [16:0] causeActive;
  output        irqOut;

  wire normalEn;
  wire abnormalEn;

  assign normalEn   = maskIn[`NIM_BIT_NORMAL_SUM];
  assign abnormalEn = maskIn[`NIM_BIT_ABNORMAL_SUM];

  // ============================================================
  // normal group
  // R1: normal summary gating
  // R16: transmit complete cause
  assign causeActive[`NIM_BIT_TX_DONE] = statusIn[0] & maskIn[0] & normalEn;
  // R14: tx buffer unavailable
  assign causeActive[`NIM_BIT_TX_NOBUF] = statusIn[2] & maskIn[2] & normalEn;
  // R11: receive complete cause
  assign causeActive[`NIM_BIT_RX_DONE] = statusIn[6] & maskIn[6] & normalEn;
  // R7: early tx uses normal
  assign causeActive[`NIM_BIT_EARLY_TX] = statusIn[10] & maskIn[10] & normalEn;

  // ============================================================
  // abnormal group
  // R2: abnormal summary gating
  // R15: tx stopped cause
  assign causeActive[`NIM_BIT_TX_STOP] = statusIn[1] & maskIn[1] & abnormalEn;
  // R13: jabber expiry cause
  assign causeActive[`NIM_BIT_TX_JABBER] = statusIn[3] & maskIn[3] & abnormalEn;
  assign causeActive[`NIM_BIT_RESERVED] = 1'b0;
  // R12: tx underrun cause
  assign causeActive[`NIM_BIT_TX_UNDER] = statusIn[5] & maskIn[5] & abnormalEn;
  // R10: rx buffer unavailable
  assign causeActive[`NIM_BIT_RX_NOBUF] = statusIn[7] & maskIn[7] & abnormalEn;
  // R9: rx stopped cause
  assign causeActive[`NIM_BIT_RX_STOP] = statusIn[8] & maskIn[8] & abnormalEn;
  // R8: rx watchdog cause
  assign causeActive[`NIM_BIT_RX_WDOG] = statusIn[9] & maskIn[9] & abnormalEn;
  // R6: timer expiry cause
  assign causeActive[`NIM_BIT_TIMER] = statusIn[11] & maskIn[11] & abnormalEn;
  // R4: bus error cause
  assign causeActive[`NIM_BIT_BUS_ERR] = statusIn[13] & maskIn[13] & abnormalEn;

  // ============================================================
  // own-enable causes with no summary gate
  // R5: link change cause
  assign causeActive[`NIM_BIT_LINK_CHG] = statusIn[12] & maskIn[12];
  // R3: early receive cause
  assign causeActive[`NIM_BIT_EARLY_RX] = statusIn[14] & maskIn[14];
  assign causeActive[16:15] = 2'b00;

  // R21: or of all causes
  assign irqOut = |causeActive;
endmodule // nim_cause_gate

// [rtl/nim_irq_mask_top.v]
// interrupt mask register, drop counters and avalon slave
// Operation
// R1: normal summary gates bits 0,2,6,10
// R2: abnormal summary gates remaining causes; the code gates causes 12 and 14 by their own mask bits only
// R3: mask bit 14 enables early receive
// R4: bus error needs 13,15,status13
// R5: mask bit 12 enables link change
// R6: timer needs 11,15,status11
// R7: early tx needs 10,16,status10
// R8: rx watchdog needs 9,15,status9
// R9: rx stopped needs 8,15,status8
// R10: rx nobuf needs 7,15,status7
// R11: rx done needs 6,16,status6
// R12: tx underrun needs 5,15,status5
// R13: jabber needs 3,15,status3
// R14: tx nobuf needs 2,16,status2
// R15: tx stopped needs 1,15,status1
// R16: tx done needs 0,16,status0
// R17: 14-bit purged frame counter bits 30:17
// R18: bit 31 flags purged count wrap
// R19: 16-bit missed frame counter bits 15:0
// R20: bit 16 flags missed count wrap
// R21: irq is or of enabled causes
`include "nim_map.vh"

module nim_irq_mask_top (
  sys_clk,
  rst_b,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest,
  avs_response,
  irqStatus,
  busErrKind,
  purgedFrame,
  missedFrame,
  hostIrq
);
  input         sys_clk;
  input         rst_b;
  input  [3:0]  avs_address;
  input         avs_read;
  input         avs_write;
  input  [31:0] avs_writedata;
  input  [3:0]  avs_byteenable;
  output [31:0] avs_readdata;
  output        avs_waitrequest;
  output [1:0]  avs_response;
  input  [16:0] irqStatus;
  input  [1:0]  busErrKind;
  input         purgedFrame;
  input         missedFrame;
  output        hostIrq;

  reg  [16:0] mask_reg;
  reg  [16:0] mask_next;
  reg  [31:0] rdata_reg;
  reg  [31:0] rdata_next;
  reg  [1:0]  resp_reg;
  reg  [1:0]  resp_next;
  reg         ack_reg;
  reg         irq_reg;
  wire [16:0] causeActive;
  wire        irqComb;
  wire [13:0] purgedCount;
  wire        purgedWrap;
  wire [15:0] missedCount;
  wire        missedWrap;
  wire [31:0] dropWord;
  wire [31:0] beMask;
  wire        busReq;
  wire        busDone;

  // ============================================================
  // byte enable expansion
  function [31:0] expandBe;
    input [3:0] be;
    begin
      expandBe = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  assign beMask = expandBe(avs_byteenable);
  assign busReq = (avs_read | avs_write) & ~ack_reg;
  // second cycle of a request, waitrequest low
  assign busDone = (avs_read | avs_write) & ack_reg;

  // one wait cycle, answer on second cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata    = rdata_reg;
  assign avs_response    = resp_reg;
  assign hostIrq         = irq_reg;

  // ============================================================
  // drop counters
  // R17: purged frame counting
  // R18: purged wrap flag
  nim_drop_counter #(
    .WIDTH (`NIM_PURGED_WIDTH)
  ) uPurged (
    .sysClk     (sys_clk),
    .rstB       (rst_b),
    .countPulse (purgedFrame),
    .countValue (purgedCount),
    .wrapFlag   (purgedWrap)
  );

  // R19: missed frame counting
  // R20: missed wrap flag
  nim_drop_counter #(
    .WIDTH (`NIM_MISSED_WIDTH)
  ) uMissed (
    .sysClk     (sys_clk),
    .rstB       (rst_b),
    .countPulse (missedFrame),
    .countValue (missedCount),
    .wrapFlag   (missedWrap)
  );

  assign dropWord = {purgedWrap, purgedCount, missedWrap, missedCount};

  // ============================================================
  // cause gating
  nim_cause_gate uGate (
    .statusIn    (irqStatus),
    .maskIn      (mask_reg),
    .causeActive (causeActive),
    .irqOut      (irqComb)
  );

  // ============================================================
  // register write and read decode
  always @*
  begin
    mask_next  = mask_reg;
    rdata_next = rdata_reg;
    resp_next  = resp_reg;
    if (busReq)
    begin
      resp_next = 2'b00;
      case (avs_address)
        `NIM_OFF_IRQ_MASK:
          rdata_next = {15'h0000, mask_reg};
        `NIM_OFF_DROP_CNT:
          rdata_next = dropWord;   // writes ignored, read only
        `NIM_OFF_STATUS_VIEW:
          rdata_next = {7'h00, busErrKind, 6'h00, irqStatus};  // R4 error kind
        default:
        begin
          rdata_next = 32'h0000_0000;
          resp_next  = 2'b11;     // decode error
        end
      endcase
      if (avs_write)
        rdata_next = 32'h0000_0000;
    end
    // mask write lands only on the edge that ends the second cycle, with waitrequest low
    if (busDone & avs_write & (avs_address == `NIM_OFF_IRQ_MASK))
      mask_next = (mask_reg & ~(beMask[16:0] & `NIM_MASK_WRITABLE)) |
                  (avs_writedata[16:0] & beMask[16:0] & `NIM_MASK_WRITABLE);
  end

  // ============================================================
  // state registers
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      mask_reg  <= `NIM_MASK_RESET;
      rdata_reg <= 32'h0000_0000;
      resp_reg  <= 2'b00;
      ack_reg   <= 1'b0;
      irq_reg   <= 1'b0;
    end
    else
    begin
      mask_reg  <= mask_next;
      rdata_reg <= rdata_next;
      resp_reg  <= resp_next;
      ack_reg   <= busReq;
      // R21: registered interrupt line
      irq_reg   <= irqComb;
    end
  end
endmodule // nim_irq_mask_top

// [verif/nim_irq_mask_asserts.sv]
// checker for irq gating and register port timing
module nim_irq_mask_asserts (
  input logic        sys_clk,
  input logic        rst_b,
  input logic [3:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0]  avs_byteenable,
  input logic        avs_waitrequest,
  input logic [1:0]  avs_response,
  input logic [16:0] irqStatus,
  input logic        hostIrq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [16:0] mask_reg;
  logic [16:0] lanes;
  logic [16:0] act;
  logic        want;
  // ============================================================
  // mask mirror and expected irq level
  assign lanes = {avs_byteenable[2], {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} & 17'h1_FFEF;
  assign act = irqStatus & mask_reg;
  assign want = (|(act & 17'h0_0445) & mask_reg[16]) | (|(act & 17'h0_2BAA) & mask_reg[15])
              | (|(act & 17'h0_5000));
  always @(posedge sys_clk)
  begin
    if (!rst_b)
      mask_reg <= 17'h0_0000;
    else if (avs_write && !avs_waitrequest && avs_address == 4'h0)
      mask_reg <= (mask_reg & ~lanes) | (avs_writedata[16:0] & lanes);
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_ack;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  property p_or; hostIrq == $past(want); endproperty
  property p_norm; |(act & 17'h0_0445) && mask_reg[16] |=> hostIrq; endproperty
  property p_abn; |(act & 17'h0_2BAA) && mask_reg[15] |=> hostIrq; endproperty
  property p_erx; act[14] |=> hostIrq; endproperty
  property p_link; act[12] |=> hostIrq; endproperty
  property p_etx; act == 17'h0_0400 && !mask_reg[16] |=> !hostIrq; endproperty
  property p_berr; act == 17'h0_2000 && !mask_reg[15] |=> !hostIrq; endproperty
  property p_wait; $rose(avs_read || avs_write) |-> s_ack; endproperty
  property p_unmap; avs_read && !avs_waitrequest && avs_address == 4'hC |-> avs_response == 2'b11;
  endproperty
  a_or: assert property (p_or) else $error("irq level wrong");
  a_norm: assert property (p_norm) else $error("normal irq lost");
  a_abn: assert property (p_abn) else $error("abnormal irq lost");
  a_erx: assert property (p_erx) else $error("early rx irq lost");
  a_link: assert property (p_link) else $error("link irq lost");
  a_etx: assert property (p_etx) else $error("early tx ungated");
  a_berr: assert property (p_berr) else $error("bus error ungated");
  a_wait: assert property (p_wait) else $error("wait state wrong");
  a_unmap: assert property (p_unmap) else $error("unmapped response wrong");
endmodule // nim_irq_mask_asserts

bind nim_irq_mask_top nim_irq_mask_asserts u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .irqStatus(irqStatus), .hostIrq(hostIrq));

// [verif/nim_host_model.sv]
// host bus master model for the register port
module nim_host_model (
  input  logic        sys_clk,
  input  logic        avs_waitrequest,
  output logic [3:0]  avs_address = 4'h0,
  output logic        avs_read = 1'b0,
  output logic        avs_write = 1'b0,
  output logic [31:0] avs_writedata = 32'h0000_0000,
  output logic [3:0]  avs_byteenable = 4'h0
);
  timeunit 1ns;
  timeprecision 100ps;
  int tmo = 0;
  // one transfer, optional idle gap, bounded wait
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] b, input int gap);
    int n;
    repeat (gap + 1) @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    avs_read <= !w;
    avs_write <= w;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40)
      tmo++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // released address and data lines show inverted values
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask
endmodule // nim_host_model

// [verif/nim_irq_mask_and_drop_counters_tb.sv]
// self-checking bench for irq mask and drop counters
module nim_irq_mask_and_drop_counters_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, rst_b = 0, purgedFrame = 0, missedFrame = 0, avs_read, avs_write;
  logic avs_waitrequest, hostIrq;
  logic [16:0] irqStatus = 17'h0_0000, m, s, g;
  logic [1:0] busErrKind = 2'b00, avs_response;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic [15:0] rnd = 16'h000E;
  logic [34:0] expQ[$];
  logic [34:0] e;
  int err_total = 0, n_compared = 0;
  always #12.5 sys_clk = ~sys_clk;
  nim_irq_mask_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest), .irqStatus(irqStatus), .busErrKind(busErrKind),
    .purgedFrame(purgedFrame), .missedFrame(missedFrame), .hostIrq(hostIrq));
  nim_host_model u_host (.sys_clk(sys_clk), .avs_waitrequest(avs_waitrequest),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));
  // ============================================================
  // helpers
  function logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function logic irqOf(input logic [16:0] mk, input logic [16:0] st);
    return (|(mk & st & 17'h0_0445) & mk[16]) | (|(mk & st & 17'h0_2BAA) & mk[15])
         | (|(mk & st & 17'h0_5000));
  endfunction
  task automatic cmp(input string what, input logic [33:0] ex, input logic [33:0] got);
    n_compared++;
    if (got !== ex)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, ex, got);
    end
  endtask
  task rd(input logic [3:0] a, input logic [33:0] ex, input logic dc);
    expQ.push_back({dc, ex});
    u_host.xfer(1'b0, a, 32'h0000_0000, 4'hF, n_compared % 3);
  endtask
  task setIrq(input logic [16:0] mk, input logic [16:0] st);
    u_host.xfer(1'b1, 4'h0, {15'h0000, mk}, 4'hF, 0);
    @(posedge sys_clk);
    irqStatus <= st;
    repeat (3) @(posedge sys_clk);
    cmp("hostIrq", {33'h0_0000_0000, irqOf(mk, st)}, {33'h0_0000_0000, hostIrq});
  endtask
  task pulses(input int nm, input int np);
    for (int k = 0; k < nm || k < np; k++)
    begin
      @(posedge sys_clk);
      missedFrame <= (k < nm);
      purgedFrame <= (k < np);
    end
    @(posedge sys_clk);
    missedFrame <= 1'b0;
    purgedFrame <= 1'b0;
  endtask
  task give_verdict;
    err_total += u_host.tmo;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // read results against oldest note
  always @(posedge sys_clk)
  begin
    if (avs_read && !avs_waitrequest)
    begin
      e = expQ.pop_front();
      cmp("readback", e[33:0], {avs_response, e[34] ? e[31:0] : avs_readdata});
    end
  end
  // hang guard
  initial
  begin
    repeat (95000) @(posedge sys_clk);
    err_total++;
    give_verdict;
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(4'h0, 34'h0_0000_0000, 0);
    rd(4'h4, 34'h0_0000_0000, 0);
    u_host.xfer(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hF, 0);
    rd(4'h0, 34'h0_0001_FFEF, 0);
    u_host.xfer(1'b1, 4'h0, 32'h0000_0000, 4'h4, 0);
    rd(4'h0, 34'h0_0000_FFEF, 0);
    $display("done: reset and mask access");
    for (int i = 0; i < 15; i++)
    begin
      s = 17'h0_0001 << i;
      g = (s & 17'h0_0445) != 0 ? 17'h1_0000 : ((s & 17'h0_2BAA) != 0 ? 17'h0_8000 : 17'h0_0000);
      if (i != 4)
      begin
        setIrq(s | g, s);
        setIrq(s, s);
        setIrq(g | (~s & 17'h1_FFEF), s);
      end
    end
    for (int j = 0; j < 20; j++)
    begin
      rnd = lfsr(rnd);
      m = {rnd, rnd[3]} & 17'h1_FFEF;
      rnd = lfsr(rnd);
      setIrq(m, {1'b0, rnd} & 17'h0_7FEF);
    end
    $display("done: irq gating");
    @(posedge sys_clk);
    busErrKind <= 2'b10;
    irqStatus <= 17'h0_2000;
    rd(4'h8, {2'b00, 7'h00, 2'b10, 6'h00, 17'h0_2000}, 0);
    pulses(3, 5);
    rd(4'h4, {2'b00, 1'b0, 14'h0005, 1'b0, 16'h0003}, 0);
    u_host.xfer(1'b1, 4'h4, 32'hFFFF_FFFF, 4'hF, 0);
    rd(4'h4, {2'b00, 1'b0, 14'h0005, 1'b0, 16'h0003}, 0);
    pulses(65536, 16384);
    rd(4'h4, {2'b00, 1'b1, 14'h0005, 1'b1, 16'h0003}, 0);
    rd(4'hC, {2'b11, 32'h0000_0000}, 1);
    $display("done: counters and decode");
    @(posedge sys_clk);
    give_verdict;
  end
endmodule // nim_irq_mask_and_drop_counters_tb
